// >>> hw/flash_front.sv
// Pin-level front end of a serial flash: framing, buffers, protection, timing.
//
// Behaviour
// - A select fall starts an operation; a select rise ends it.
// - Deselected: input ignored, output undriven, device in standby.
// - Standby is withheld until a running program, erase or page-to-buffer copy completes.
// - Input bits are sampled on each serial clock rising edge.
// - Output bits change on each serial clock falling edge.
// - Write protect low protects every sector flagged in the protection register.
// - Write protect low freezes the protection register contents.
// - Program or erase under write protect is dropped; idle after deselect.
// - Protection enable and sector lockdown still work under write protect.
// - Write protect reads deasserted when floating, through an external pull-up.
// - Reset pin low aborts the operation and returns to idle.
// - The device stays reset while the reset pin is low.
// - Power-on reset initialises all state except the buffer contents; reset pin needs no sequencing.
// - Pages of 512 or 528 bytes, page count fixed.
// - Two page-sized buffers; the one not being programmed accepts data while a page programs.
// - Program and erase durations are timed internally.
// - Byte alteration: page to buffer, modify buffer, buffer to page.
// - All bytes travel most significant bit first.
`timescale 1ns/10ps
module flash_front (
    // Clock and power-on reset
    input wire logic mclk,
    input wire logic resetn,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // Control pins
    input wire logic wp_n,
    input wire logic rst_pin_n,
    // Status
    output logic standby,
    output logic busy,
    output logic wr_stall,
    // Main array macro, read data valid the cycle after arr_re
    output logic [flash_pkg::ARR_W-1:0] arr_addr,
    output logic arr_we,
    output logic arr_re,
    output logic arr_erase,
    output logic [7:0] arr_wdata,
    input wire logic [7:0] arr_rdata
);
    import flash_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] sck_s;
        logic [1:0] si_s;
        logic [1:0] wp_s;
        logic [1:0] rp_s;
        logic sck_p;
        logic cs_p;
        logic [2:0] bitcnt;
        logic [7:0] rx;
        logic [7:0] opc;
        logic [7:0] tx;
        ph_t ph;
        logic [1:0] nadr;
        logic [23:0] adr;
        logic [COL_W-1:0] bptr;
        logic so;
        logic oe;
        eng_t eng;
        logic ebuf;
        logic [1:0] eph;
        logic [PAGE_W-1:0] epg;
        logic [COL_W-1:0] eidx;
        logic [CNT_W-1:0] ecnt;
        logic a_we;
        logic a_re;
        logic a_er;
        logic [ARR_W-1:0] a_adr;
        logic [7:0] a_wd;
        logic prot_en;
        logic bin;
        logic [NSECT-1:0] prot;
        logic [NSECT-1:0] lock;
    } st_t;

    st_t q;
    st_t n;
    logic [7:0] buf_mem [2][PAGE_STD];
    byte_fifo_if #(.W(FIFO_W)) bf ();

    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic op_is(input logic [7:0] o, input logic [7:0] base);
        op_is = (o[7:1] == base[7:1]);
    endfunction : op_is

    function automatic logic is_prog(input logic [7:0] o);
        is_prog = op_is(o, OP_B2P) | (o == OP_ERASE);
    endfunction : is_prog

    function automatic logic needs_adr(input logic [7:0] o);
        needs_adr = op_is(o, OP_BUF_WR) | op_is(o, OP_BUF_RD) | op_is(o, OP_B2P) |
                    op_is(o, OP_P2B) | (o == OP_ERASE) | (o == OP_LOCK);
    endfunction : needs_adr

    function automatic logic [PAGE_W-1:0] page_of(input logic [23:0] a, input logic b);
        page_of = b ? a[COL_W-1 +: PAGE_W] : a[COL_W +: PAGE_W];
    endfunction : page_of

    function automatic logic [COL_W-1:0] wrap(input logic [COL_W-1:0] c, input logic [COL_W-1:0] pb);
        wrap = (c >= pb) ? '0 : c;
    endfunction : wrap

    // ****************************************
    // Pin events, all read from second synchroniser stages
    // ****************************************
    logic sel, rise, fall, cs_rise, cs_fall, wp_low, pin_rst, byte_end, launch, blocked, pop, bw_en;
    logic [COL_W-1:0] pb;
    logic [7:0] rx_byte;
    logic [7:0] sbyte;
    logic [SECT_W-1:0] sect;
    logic [PAGE_W-1:0] cur_pg;

    assign sel = ~q.cs_s[1];
    assign rise = q.sck_s[1] & ~q.sck_p & sel;
    assign fall = ~q.sck_s[1] & q.sck_p & sel;
    assign cs_rise = q.cs_s[1] & ~q.cs_p;
    assign cs_fall = ~q.cs_s[1] & q.cs_p;
    assign wp_low = ~q.wp_s[1];
    assign pin_rst = ~q.rp_s[1];
    assign pb = q.bin ? PAGE_BIN : PAGE_STD;
    assign rx_byte = {q.rx[6:0], q.si_s[1]};
    assign byte_end = rise & (q.bitcnt == 3'h7);
    assign busy = (q.eng != E_IDLE);
    assign cur_pg = page_of(q.adr, q.bin);
    assign sect = cur_pg[PAGE_W-1 -: SECT_W];
    assign blocked = q.lock[sect] | ((q.prot_en | wp_low) & q.prot[sect]);
    assign launch = cs_rise & (q.ph == PH_DAT) & ~busy & ~pin_rst &
                    ((is_prog(q.opc) & ~wp_low & ~blocked) | op_is(q.opc, OP_P2B));
    assign bw_en = (q.eng == E_IN) & (q.eph == 2'h2) & ~pin_rst;
    // A buffer that the engine is copying cannot also take host data; the other one can.
    assign bf.out_ready = ~(((q.eng == E_OUT) | (q.eng == E_IN)) & (q.ebuf == bf.out_data[FIFO_W-1]));
    assign pop = bf.out_valid & bf.out_ready;
    assign bf.in_valid = byte_end & (q.ph == PH_DAT) & op_is(q.opc, OP_BUF_WR);
    assign bf.in_data = {q.opc[0], q.bptr, rx_byte};
    assign wr_stall = ~bf.in_ready;

    xfer_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .f(bf.store)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [COL_W-1:0] fidx;
        fidx = q.bptr;
        n = q;
        sbyte = '0;
        sbyte[ST_RDY] = ~busy;
        sbyte[ST_PROT] = q.prot_en;
        sbyte[ST_BIN] = q.bin;
        n.cs_s = {q.cs_s[0], cs_n};
        n.sck_s = {q.sck_s[0], sck};
        n.si_s = {q.si_s[0], si};
        n.wp_s = {q.wp_s[0], wp_n};
        n.rp_s = {q.rp_s[0], rst_pin_n};
        n.sck_p = q.sck_s[1];
        n.cs_p = q.cs_s[1];
        n.a_we = 1'b0;
        n.a_re = 1'b0;
        n.a_er = 1'b0;
        if (!sel) begin
            n.bitcnt = '0;
            n.oe = 1'b0;
        end else begin
            n.oe = 1'b1;
            if (cs_fall) begin
                n.ph = PH_OPC;
                n.nadr = '0;
            end
            if (rise) begin
                n.rx = rx_byte;
                n.bitcnt = q.bitcnt + 1'b1;
            end
            if (fall) begin
                n.so = q.tx[7];
                n.tx = {q.tx[6:0], 1'b0};
            end
            if (byte_end) begin
                case (q.ph)
                    PH_OPC: begin
                        n.opc = rx_byte;
                        n.ph = needs_adr(rx_byte) ? PH_ADR : PH_DAT;
                        if (rx_byte == OP_STATUS) begin
                            n.tx = sbyte;
                        end
                    end
                    PH_ADR: begin
                        n.adr = {q.adr[15:0], rx_byte};
                        n.nadr = q.nadr + 1'b1;
                        if (q.nadr == 2'h2) begin
                            n.ph = PH_DAT;
                            fidx = q.bin ? {1'b0, q.adr[0], rx_byte} : {q.adr[1:0], rx_byte};
                            fidx = wrap(fidx, pb);
                            n.bptr = fidx;
                            if (op_is(q.opc, OP_BUF_RD)) begin
                                n.tx = buf_mem[q.opc[0]][fidx];
                                n.bptr = wrap(fidx + 1'b1, pb);
                            end
                        end
                    end
                    PH_DAT: begin
                        if (op_is(q.opc, OP_BUF_RD)) begin
                            n.tx = buf_mem[q.opc[0]][q.bptr];
                            n.bptr = wrap(q.bptr + 1'b1, pb);
                        end else if (op_is(q.opc, OP_BUF_WR) && bf.in_ready) begin
                            n.bptr = wrap(q.bptr + 1'b1, pb);
                        end else if (q.opc == OP_STATUS) begin
                            n.tx = sbyte;
                        end else if (q.opc == OP_PROT_WR && !wp_low) begin
                            n.prot = {q.prot[NSECT-9:0], rx_byte};
                        end
                    end
                    default: n.ph = PH_OPC;
                endcase
            end
        end
        // Commands act on deselect so that a truncated frame does nothing.
        if (cs_rise && q.ph == PH_DAT) begin
            n.ph = PH_OPC;
            if (q.opc == OP_PROT_EN) begin
                n.prot_en = 1'b1;
            end else if (q.opc == OP_PROT_DIS && !wp_low) begin
                n.prot_en = 1'b0;
            end else if (q.opc == OP_LOCK) begin
                n.lock[sect] = 1'b1;
            end else if (q.opc == OP_BIN && !busy) begin
                n.bin = 1'b1;
            end
        end
        if (launch) begin
            n.epg = page_of(q.adr, q.bin);
            n.ebuf = q.opc[0];
            n.eidx = '0;
            n.eph = '0;
            n.a_adr = {page_of(q.adr, q.bin), {COL_W{1'b0}}};
            if (op_is(q.opc, OP_P2B)) begin
                n.eng = E_IN;
            end else if (op_is(q.opc, OP_B2P)) begin
                n.a_er = 1'b1;
                n.eng = E_OUT;
            end else begin
                n.a_er = 1'b1;
                n.eng = E_WAIT;
                n.ecnt = CNT_W'(ERASE_CYC);
            end
        end
        // ****************************************
        // Array engine
        // ****************************************
        case (q.eng)
            E_OUT: begin
                n.a_we = 1'b1;
                n.a_adr = {q.epg, q.eidx};
                n.a_wd = buf_mem[q.ebuf][q.eidx];
                n.eidx = q.eidx + 1'b1;
                if (q.eidx == pb - 1'b1) begin
                    n.eng = E_WAIT;
                    n.ecnt = CNT_W'(PROG_CYC);
                end
            end
            E_IN: begin
                n.eph = q.eph + 1'b1;
                if (q.eph == 2'h0) begin
                    n.a_re = 1'b1;
                    n.a_adr = {q.epg, q.eidx};
                end else if (q.eph == 2'h2) begin
                    n.eph = '0;
                    n.eidx = q.eidx + 1'b1;
                    if (q.eidx == pb - 1'b1) begin
                        n.eng = E_IDLE;
                    end
                end
            end
            E_WAIT: begin
                if (q.ecnt == '0) begin
                    n.eng = E_IDLE;
                end else begin
                    n.ecnt = q.ecnt - 1'b1;
                end
            end
            default: ;
        endcase
        if (pin_rst) begin
            n.eng = E_IDLE;
            n.ph = PH_OPC;
            n.bitcnt = '0;
            n.a_we = 1'b0;
            n.a_re = 1'b0;
            n.a_er = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.cs_s <= 2'h3;
            q.cs_p <= 1'b1;
            q.wp_s <= 2'h3;
            q.rp_s <= 2'h3;
        end else begin
            q <= n;
        end
    end

    // Buffer storage has no reset; contents are undefined until written.
    always_ff @(posedge mclk) begin
        if (bw_en) begin
            buf_mem[q.ebuf][q.eidx] <= arr_rdata;
        end
        if (pop) begin
            buf_mem[bf.out_data[FIFO_W-1]][bf.out_data[8 +: COL_W]] <= bf.out_data[7:0];
        end
    end

    assign so = q.so;
    assign so_oe = q.oe;
    assign standby = q.cs_s[1] & ~busy;
    assign arr_addr = q.a_adr;
    assign arr_we = q.a_we;
    assign arr_re = q.a_re;
    assign arr_erase = q.a_er;
    assign arr_wdata = q.a_wd;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_wait_entry;
        (q.eng != E_WAIT) ##1 (q.eng == E_WAIT) && !pin_rst;
    endsequence
    sequence s_wait_hold;
        (q.eng == E_WAIT && !standby) [*8];
    endsequence

    a_so_released: assert property (!sel |=> !so_oe)
        else $error("Output driven while deselected.");
    a_input_ignored: assert property (!sel |=> (q.bitcnt == 3'h0) && $stable(q.rx))
        else $error("Input shifted while deselected.");
    a_busy_standby: assert property (busy |-> !standby)
        else $error("Standby while internal operation runs.");
    a_rise_sample: assert property (rise |=> q.rx == {$past(q.rx[6:0]), $past(q.si_s[1])})
        else $error("Input not sampled on rising edge.");
    a_fall_drive: assert property ((sel && !fall) |=> $stable(so))
        else $error("Output moved outside a falling edge.");
    a_wp_drop: assert property ((cs_rise && q.ph == PH_DAT && is_prog(q.opc) && wp_low && !busy)
        |=> (!busy && !arr_erase))
        else $error("Program or erase started under protection.");
    a_prot_frozen: assert property ((wp_low && sel) |=> $stable(q.prot))
        else $error("Protection register changed under write protect.");
    a_reset_idle: assert property (pin_rst |=> (q.eng == E_IDLE) && !arr_we)
        else $error("Engine active during reset pin.");
    a_timed_wait: assert property (s_wait_entry |-> s_wait_hold)
        else $error("Self-timed wait ended too early.");
    a_enable_wp: assert property ((cs_rise && q.ph == PH_DAT && q.opc == OP_PROT_EN) |=> q.prot_en)
        else $error("Protection enable ignored.");
endmodule : flash_front

// >>> pkg/flash_pkg.sv
// Shared constants, opcodes and state types of the serial flash front end.
package flash_pkg;
    // ****************************************
    // Array organisation
    // ****************************************
    localparam int PAGE_W = 12;
    localparam int COL_W = 10;
    localparam int ARR_W = PAGE_W + COL_W;
    localparam logic [PAGE_W:0] PAGE_COUNT = 13'h1000;
    localparam logic [COL_W-1:0] PAGE_STD = 10'h210;
    localparam logic [COL_W-1:0] PAGE_BIN = 10'h200;
    localparam int SECT_W = 4;
    localparam int NSECT = 16;
    localparam int FIFO_W = 1 + COL_W + 8;
    localparam int FIFO_D = 8;
    // ****************************************
    // Opcodes; bit 0 selects the buffer where one is involved
    // ****************************************
    localparam logic [7:0] OP_BUF_WR = 8'h10;
    localparam logic [7:0] OP_BUF_RD = 8'h20;
    localparam logic [7:0] OP_B2P = 8'h30;
    localparam logic [7:0] OP_P2B = 8'h40;
    localparam logic [7:0] OP_ERASE = 8'h50;
    localparam logic [7:0] OP_STATUS = 8'h60;
    localparam logic [7:0] OP_PROT_EN = 8'h70;
    localparam logic [7:0] OP_PROT_DIS = 8'h72;
    localparam logic [7:0] OP_PROT_WR = 8'h74;
    localparam logic [7:0] OP_LOCK = 8'h76;
    localparam logic [7:0] OP_BIN = 8'h78;
    // ****************************************
    // Status byte fields and self-timed durations
    // ****************************************
    localparam int ST_RDY = 7;
    localparam int ST_PROT = 1;
    localparam int ST_BIN = 0;
    localparam int CLK_NS = 8;
    localparam int PROG_NS = 2000;
    localparam int ERASE_NS = 4000;
    localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 16;
    typedef enum logic [1:0] {PH_OPC, PH_ADR, PH_DAT} ph_t;
    typedef enum logic [1:0] {E_IDLE, E_OUT, E_IN, E_WAIT} eng_t;
endpackage : flash_pkg

// >>> pkg/byte_fifo_if.sv
// Valid/ready carrier between the frame logic and the write FIFO.
`timescale 1ns/10ps
interface byte_fifo_if #(parameter int W = 8);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport push (output in_valid, output in_data, input in_ready);
    modport store (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
    modport drain (input out_valid, input out_data, output out_ready);
endinterface : byte_fifo_if

// >>> hw/xfer_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module xfer_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Both sides
    byte_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fst_t;
    fst_t q;
    fst_t d;
    logic push;
    logic pop;

    assign f.in_ready = (q.cnt != (AW+1)'(DEPTH));
    assign f.out_valid = (q.cnt != '0);
    assign f.out_data = q.mem[q.rd];
    assign push = f.in_valid & f.in_ready;
    assign pop = f.out_valid & f.out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = f.in_data;
            d.wr = q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = q.rd + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    a_fifo_bound: assert property (@(posedge mclk) disable iff (!resetn)
        (q.cnt == (AW+1)'(DEPTH)) |-> !f.in_ready)
        else $error("FIFO accepts data while full.");
endmodule : xfer_fifo

// >>> verification/flash_host_model.sv
// Host-side serial bus controller model driving select, serial clock and input data.
`timescale 1ns/10ps
module flash_host_model (
    // Clock
    input wire logic mclk,
    // Serial pins
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so_line
);
    // ****************************************
    // Mode 0 framing and shifting
    // ****************************************
    // Six system clocks per half period give the synchronised output path time to settle before sampling.
    localparam int HALF = 6;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task automatic gap();
        repeat (HALF) @(posedge mclk);
    endtask : gap
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            gap();
            sck <= 1'b1;
            rx[i] = so_line;
            gap();
            sck <= 1'b0;
        end
    endtask : shift
    task automatic header(input logic [7:0] opc, input logic [23:0] adr, input logic has_adr);
        logic [7:0] r;
        @(posedge mclk);
        cs_n <= 1'b0;
        gap();
        shift(opc, r);
        if (has_adr) begin
            for (int i = 2; i >= 0; i--) shift(adr[8*i +: 8], r);
        end
    endtask : header
    // The data line toggles once at deselect, so a device that listened would see garbage.
    task automatic deselect();
        gap();
        cs_n <= 1'b1;
        si <= ~si;
        gap();
    endtask : deselect
endmodule : flash_host_model

// >>> verification/serial_flash_pin_interface_bench.sv
// Self-checking testbench of the serial flash pin front end.
`timescale 1ns/10ps
module serial_flash_pin_interface_bench;
    import flash_pkg::*;
    logic mclk, resetn, rst_pin_n, wp_drv, wp_en, cs_n, sck, si, so, so_oe, standby, busy, wr_stall;
    logic arr_we, arr_re, arr_erase, stall_seen;
    logic [ARR_W-1:0] arr_addr;
    logic [7:0] arr_wdata, arr_rdata, wd0;
    logic [7:0] wq[$];
    tri1 wp_line;
    wire so_line;
    int errors, tests_run, we_cnt, erase_cnt, busy_cnt;
    assign wp_line = wp_en ? wp_drv : 1'bz;
    assign so_line = so_oe ? so : 1'bz;
    flash_front u_dut (.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
        .wp_n(wp_line), .rst_pin_n(rst_pin_n), .standby(standby), .busy(busy), .wr_stall(wr_stall),
        .arr_addr(arr_addr), .arr_we(arr_we), .arr_re(arr_re), .arr_erase(arr_erase), .arr_wdata(arr_wdata),
        .arr_rdata(arr_rdata));
    flash_host_model u_host (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .so_line(so_line));
    // ****************************************
    // Clock and array macro model
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    function automatic logic [7:0] arr_pattern(input logic [ARR_W-1:0] a);
        return a[7:0] ^ a[21:14];
    endfunction : arr_pattern
    always @(posedge mclk) begin
        arr_rdata <= arr_pattern(arr_addr);
        if (arr_we === 1'b1) we_cnt++;
        if (arr_erase === 1'b1) erase_cnt++;
        if (arr_we === 1'b1 && arr_addr[9:0] === 10'h000) wd0 = arr_wdata;
        if (busy === 1'b1) busy_cnt++;
        if (wr_stall === 1'b1) stall_seen = 1'b1;
    end
    // ****************************************
    // Checking and transfer tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    task automatic cmd(input logic [7:0] opc);
        u_host.header(opc, 24'h000000, 1'b0);
        u_host.deselect();
    endtask : cmd
    task automatic status_check(input logic [7:0] exp);
        logic [7:0] r;
        u_host.header(OP_STATUS, 24'h000000, 1'b0);
        u_host.shift(8'h00, r);
        check("status byte", 16'(exp), 16'(r));
        check("output enable selected", 16'h0001, 16'(so_oe));
        u_host.deselect();
        check("output enable deselected", 16'h0000, 16'(so_oe));
    endtask : status_check
    task automatic buf_write(input logic b, input logic [9:0] col, input int n);
        logic [7:0] r;
        wq.delete();
        for (int i = 0; i < n; i++) wq.push_back(8'($urandom));
        u_host.header(OP_BUF_WR | {7'h00, b}, {14'h0000, col}, 1'b1);
        foreach (wq[i]) u_host.shift(wq[i], r);
        u_host.deselect();
    endtask : buf_write
    task automatic buf_read(input logic b, input logic [9:0] col);
        logic [7:0] r;
        u_host.header(OP_BUF_RD | {7'h00, b}, {14'h0000, col}, 1'b1);
        foreach (wq[i]) begin
            u_host.shift(8'h00, r);
            check("buffer byte", 16'(wq[i]), 16'(r));
        end
        u_host.deselect();
    endtask : buf_read
    task automatic wait_idle();
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge mclk);
        check("busy clear", 16'h0000, 16'(busy));
    endtask : wait_idle
    task automatic start_op(input logic [7:0] opc, input logic [23:0] adr);
        u_host.header(opc, adr, 1'b1);
        u_host.deselect();
        repeat (4) @(posedge mclk);
    endtask : start_op
    initial begin
        #(60000 * 8);
        errors++;
        $display("Error watchdog expected finish seen hang");
        summarize();
    end
    initial begin
        logic [11:0] pg;
        logic [9:0] col;
        logic [7:0] r;
        int w0, e0, b0;
        resetn = 1'b0;
        rst_pin_n = 1'b1;
        wp_drv = 1'b1;
        wp_en = 1'b1;
        errors = 0;
        tests_run = 0;
        we_cnt = 0;
        erase_cnt = 0;
        busy_cnt = 0;
        stall_seen = 1'b0;
        void'($urandom(87385));
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        check("reset output enable", 16'h0000, 16'(so_oe));
        check("reset standby", 16'h0001, 16'(standby));
        status_check(8'h80);
        $display("test reset and status finished");
        for (int b = 0; b < 2; b++) begin
            col = (b == 1) ? 10'h20C : 10'($urandom_range(519));
            buf_write(b[0], col, 8);
            buf_read(b[0], col);
        end
        $display("test buffer round trip finished");
        pg = 12'($urandom);
        w0 = we_cnt;
        e0 = erase_cnt;
        b0 = busy_cnt;
        start_op(OP_B2P | 8'h01, {2'b00, pg, 10'h000});
        check("busy after deselect", 16'h0001, 16'(busy));
        check("standby while busy", 16'h0000, 16'(standby));
        col = 10'($urandom_range(519));
        buf_write(1'b0, col, 8);
        wait_idle();
        check("page byte writes", 16'h0210, 16'(we_cnt - w0));
        check("erase pulses", 16'h0001, 16'(erase_cnt - e0));
        check("self-timed length", 16'h0001, 16'(busy_cnt - b0 >= 528 + PROG_CYC));
        check("standby after program", 16'h0001, 16'(standby));
        buf_read(1'b0, col);
        $display("test program with interleaved write finished");
        pg = 12'($urandom);
        start_op(OP_P2B, {2'b00, pg, 10'h000});
        buf_write(1'b0, 10'h1F4, 10);
        wait_idle();
        check("fifo full seen", 16'h0001, 16'(stall_seen));
        wq.delete();
        for (int i = 0; i < 4; i++) wq.push_back(arr_pattern({pg, 10'(i)}));
        buf_read(1'b0, 10'h000);
        $display("test page to buffer finished");
        @(posedge mclk);
        wp_drv <= 1'b0;
        e0 = erase_cnt;
        start_op(OP_ERASE, {2'b00, pg, 10'h000});
        check("erase under protect", 16'h0000, 16'(busy));
        check("pulse under protect", 16'h0000, 16'(erase_cnt - e0));
        check("idle under protect", 16'h0001, 16'(standby));
        cmd(OP_PROT_EN);
        status_check(8'h82);
        @(posedge mclk);
        wp_en <= 1'b0;
        cmd(OP_PROT_DIS);
        status_check(8'h80);
        start_op(OP_ERASE, {2'b00, pg, 10'h000});
        check("erase with floating protect", 16'h0001, 16'(busy));
        $display("test write protect finished");
        @(posedge mclk);
        rst_pin_n <= 1'b0;
        repeat (8) @(posedge mclk);
        check("busy aborted", 16'h0000, 16'(busy));
        repeat (600) @(posedge mclk);
        check("busy held in reset", 16'h0000, 16'(busy));
        rst_pin_n <= 1'b1;
        repeat (4) @(posedge mclk);
        status_check(8'h80);
        $display("test reset pin finished");
        cmd(OP_BIN);
        status_check(8'h81);
        w0 = we_cnt;
        start_op(OP_B2P, {3'b000, pg, 9'h000});
        wait_idle();
        check("binary page writes", 16'h0200, 16'(we_cnt - w0));
        check("page first byte", 16'(arr_pattern({pg, 10'h000})), 16'(wd0));
        $display("test binary page finished");
        @(posedge mclk);
        wp_en <= 1'b1;
        start_op(OP_LOCK, {3'b000, 4'h3, 17'h00000});
        u_host.header(OP_PROT_WR, 24'h000000, 1'b0);
        repeat (2) u_host.shift(8'hFF, r);
        u_host.deselect();
        @(posedge mclk);
        wp_en <= 1'b0;
        cmd(OP_PROT_EN);
        start_op(OP_ERASE, {3'b000, 4'h3, 17'h00000});
        check("erase in locked sector", 16'h0000, 16'(busy));
        start_op(OP_ERASE, {3'b000, 4'h5, 17'h00000});
        check("erase with refused flags", 16'h0001, 16'(busy));
        wait_idle();
        $display("test lockdown and frozen flags finished");
        summarize();
    end
endmodule : serial_flash_pin_interface_bench
